// ---- verif/testbench.sv ----
`timescale 1ns/10ps
module testbench
  import usu_pkg::*;
();
  logic clk, arst_n, pSck, pDi, sck, di, tmr, cWr, cSrc, cEdge, cStb, cTgl, sWr, sClrOv, sClrSt, dWr;
  logic doPin, ovf, stF, sdaOe, sckO, sclOe, wIdle, wPd, tg;
  logic [3:0] sVal, cnt;
  logic [7:0] dWd, shData, s, p, r, rx;
  logic [31:0] seed;
  usu_wire_mode_t wm;
  int failures, total_checks, e, c;

  // Open-drain lines: a low enable pulls the wire down
  assign sck = pSck & sclOe;
  assign di  = pDi & sdaOe;

  usu_spi_peer u_peer (.sck(pSck), .mosi(pDi), .miso(doPin));

  usu_shift_unit u_dut (
    .clk(clk), .arst_n(arst_n), .shiftClockPin(sck), .serialDataInputPin(di), .timerZeroOverflow(tmr),
    .ctrlWrite(cWr), .ctrlWireMode(wm), .ctrlClockSource(cSrc), .ctrlClockEdge(cEdge),
    .ctrlClockStrobe(cStb), .ctrlClockPinToggle(cTgl), .statusWrite(sWr), .statusClearOverflow(sClrOv),
    .statusClearStart(sClrSt), .statusCounterValue(sVal), .dataWrite(dWr), .dataWdata(dWd),
    .shiftData_q(shData), .counter_q(cnt), .overflowFlag_q(ovf), .startFlag_q(stF), .rateViolation_q(),
    .dataOutPin_q(doPin), .sdaOut_q(), .sdaOe_n_q(sdaOe), .shiftClockPinOut_q(sckO), .sclOut_q(),
    .sclOe_n_q(sclOe), .wakeIdle_q(wIdle), .wakePowerDown_q(wPd)
  );

  always #2.5 clk = ~clk;

  task automatic rnd(output logic [7:0] v);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v = seed[7:0];
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic ctl(input logic cw, src, edg, stb, tgl, dw);
    @(negedge clk);
    {cWr, cSrc, cEdge, cStb, cTgl, dWr} = {cw, src, edg, stb, tgl, dw};
    @(negedge clk);
    {cWr, cStb, cTgl, dWr} = 4'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic st(input logic clrOv, input logic clrSt, input logic [3:0] val);
    @(negedge clk);
    {sWr, sClrOv, sClrSt, sVal} = {1'b1, clrOv, clrSt, val};
    @(negedge clk);
    sWr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #50000;
    failures++;
    give_verdict();
  end

  initial begin
    {clk, arst_n, tmr, cWr, cSrc, cEdge, cStb, cTgl, sWr, sClrOv, sClrSt, dWr, sVal, dWd} = '0;
    wm = USU_WM_OFF;
    seed = 32'h00018097;
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chkByte(shData, 8'h00);
    chkByte({4'h0, cnt}, 8'h00);
    chkBit(ovf, 1'b0);
    $display("test reset done");
    wm = USU_WM_THREE;
    for (int m = 0; m < 4; m++) begin
      rnd(s);
      rnd(p);
      dWd = s;
      ctl(1'b1, 1'b1, m[1], 1'b0, 1'b0, 1'b1);
      st(1'b1, 1'b0, 4'h0);
      u_peer.xfer(m[1], p, rx);
      repeat (8) @(negedge clk);
      chkByte(shData, p);
      chkByte(rx, s);
      chkByte({4'h0, cnt}, 8'h00);
      chkBit(ovf, 1'b1);
      chkBit(wIdle, 1'b1);
    end
    $display("test external transfers done");
    rnd(s);
    dWd = s;
    ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    st(1'b1, 1'b0, 4'hd);
    {e, c, tg} = {24'h0, s, 32'd13, 1'b0};
    for (int i = 0; i < 3; i++) begin
      rnd(r);
      u_peer.set(1'b0, r[0]);
      repeat (3) @(negedge clk);
      ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      e = ((e << 1) | r[0]) & 255;
      c = (c + 1) % 16;
      tg = ~tg;
      chkByte(shData, e[7:0]);
      chkByte({4'h0, cnt}, c[7:0]);
      chkBit(sckO, tg);
    end
    chkBit(ovf, 1'b1);
    rnd(s);
    dWd = s;
    ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    chkByte(shData, s);
    st(1'b1, 1'b0, 4'h5);
    chkByte({4'h0, cnt}, 8'h05);
    chkBit(ovf, 1'b0);
    $display("test software strobe done");
    ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    {e, c} = {24'h0, s, 32'd5};
    for (int i = 0; i < 2; i++) begin
      rnd(r);
      u_peer.set(1'b0, r[0]);
      repeat (3) @(negedge clk);
      tmr = 1'b1;
      @(negedge clk) tmr = 1'b0;
      repeat (2) @(negedge clk);
      e = ((e << 1) | r[0]) & 255;
      c = c + 1;
      chkByte(shData, e[7:0]);
      chkByte({4'h0, cnt}, c[7:0]);
    end
    $display("test timer source done");
    // Keep the data line released so the start can be seen
    dWd = 8'hff;
    wm = USU_WM_TWO;
    ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    u_peer.set(1'b1, 1'b1);
    repeat (6) @(negedge clk);
    chkBit(sclOe, 1'b1);
    u_peer.set(1'b1, 1'b0);
    repeat (8) @(negedge clk);
    chkBit(stF, 1'b1);
    chkBit(wPd, 1'b1);
    u_peer.set(1'b0, 1'b0);
    repeat (8) @(negedge clk);
    chkBit(sclOe, 1'b0);
    st(1'b0, 1'b1, 4'h0);
    chkBit(stF, 1'b0);
    $display("test two-wire start done");
    give_verdict();
  end
endmodule // testbench

// ---- verif/usu_spi_peer.sv ----
`timescale 1ns/10ps
module usu_spi_peer (
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck  = 1'b0;
    mosi = 1'b0;
  end

  // Master side of the link: the clock starts low; xfer moves it inside a frame and set drives it directly
  task automatic xfer(input logic mode, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (!mode) mosi = tx[i];
      #40 sck = 1'b1;
      if (mode) mosi = tx[i];
      else rx[i] = miso;
      #40 sck = 1'b0;
      if (mode) rx[i] = miso;
    end
    // Hold time is over, so the line no longer shows the last bit
    #40 mosi = ~mosi;
  endtask

  task automatic set(input logic c, input logic d);
    sck  = c;
    mosi = d;
  endtask
endmodule // usu_spi_peer

// ---- verilog/usu_consts.svh ----
// Notes on behaviour
// - Eight-bit shift register, direct access, unbuffered.
// - Register MSB goes to one of two pins.
// - Output latch changes pin on opposite edge.
// - Serial input always taken from data input.
// - Readable, writable 4-bit counter with overflow flag.
// - Register and counter share one clock source unless toggle counting is selected.
// - External clock counts both edges.
// - Clock from pin, timer overflow or software.
// - Two-wire start condition raises a flag.
// - Two-wire wait states hold clock line low.
// - Three-wire follows SPI modes 0/1, no select.
// - Eight pulses exchange both shift registers.
// - Edge select picks sampling and shifting edges.
// - Master clock made by toggling the pin.
// - Three-wire: master fck/2, slave fck/4 max.
// - Two-wire clock at most fck/16.
// - Sixteen edges from zero overflow the counter.
// - Counter overflow wakes from idle.
// - Data loaded half clock before first sample.
// - Two-wire start wakes from power-down only.
// - Toggle bit toggles pin and counts when selected.
// - Writing one clears flag, write loads counter.
// - Data write beats simultaneous shift.
// - Latch open first half external, always internal.
`ifndef USU_CONSTS_SVH
`define USU_CONSTS_SVH

`define USU_DATA_W          8
`define USU_CNT_W           4
`define USU_DATA_RST        8'h00
`define USU_CNT_RST         4'h0
`define USU_CNT_MAX         4'hf
`define USU_EDGES_PER_BYTE  16
`define USU_MASTER_CLK_DIV  2
`define USU_SLAVE_CLK_DIV   4
`define USU_TWI_CLK_DIV     16
`define USU_GAP_W           4

`endif

// ---- verilog/usu_edge_capture.sv ----
`timescale 1ns/10ps
module usu_edge_capture (
  input  wire logic linkClk,
  input  wire logic arst_n,
  input  wire logic dataIn,
  output logic      posBit_q,
  output logic      posTgl_q,
  output logic      negBit_q,
  output logic      negTgl_q
);

  // Each edge keeps its own sample and toggle, so the bit is stable long before the toggle is seen
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      posBit_q <= 1'b0;
      posTgl_q <= 1'b0;
    end else begin
      posBit_q <= dataIn;
      posTgl_q <= ~posTgl_q;
    end
  end

  always_ff @(negedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      negBit_q <= 1'b0;
      negTgl_q <= 1'b0;
    end else begin
      negBit_q <= dataIn;
      negTgl_q <= ~negTgl_q;
    end
  end

endmodule // usu_edge_capture

// ---- verilog/usu_pkg.sv ----
package usu_pkg;

  typedef enum logic [1:0] {
    USU_WM_OFF,
    USU_WM_THREE,
    USU_WM_TWO,
    USU_WM_TWO_HOLD
  } usu_wire_mode_t;

  function automatic logic usuIsTwoWire(input usu_wire_mode_t m);
    return (m == USU_WM_TWO) || (m == USU_WM_TWO_HOLD);
  endfunction

endpackage

// ---- verilog/usu_shift_unit.sv ----
`timescale 1ns/10ps
`include "usu_consts.svh"
module usu_shift_unit
  import usu_pkg::*;
#(
  parameter int DataW = `USU_DATA_W,
  parameter int CntW  = `USU_CNT_W
)(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             shiftClockPin,
  input  wire logic             serialDataInputPin,
  input  wire logic             timerZeroOverflow,
  input  wire logic             ctrlWrite,
  input  wire usu_wire_mode_t   ctrlWireMode,
  input  wire logic             ctrlClockSource,
  input  wire logic             ctrlClockEdge,
  input  wire logic             ctrlClockStrobe,
  input  wire logic             ctrlClockPinToggle,
  input  wire logic             statusWrite,
  input  wire logic             statusClearOverflow,
  input  wire logic             statusClearStart,
  input  wire logic [CntW-1:0]  statusCounterValue,
  input  wire logic             dataWrite,
  input  wire logic [DataW-1:0] dataWdata,
  output logic      [DataW-1:0] shiftData_q,
  output logic      [CntW-1:0]  counter_q,
  output logic                  overflowFlag_q,
  output logic                  startFlag_q,
  output logic                  rateViolation_q,
  output logic                  dataOutPin_q,
  output logic                  sdaOut_q,
  output logic                  sdaOe_n_q,
  output logic                  shiftClockPinOut_q,
  output logic                  sclOut_q,
  output logic                  sclOe_n_q,
  output logic                  wakeIdle_q,
  output logic                  wakePowerDown_q
);

  // No slave select input exists; selecting a peer is left to software

  usu_wire_mode_t wireMode_q;
  logic           srcExt_q;
  logic           edgeSel_q;
  logic           countOnToggle_q;
  logic           posBit;
  logic           posTgl;
  logic           negBit;
  logic           negTgl;
  logic [3:0]     syncd;
  logic           posTglD_q;
  logic           negTglD_q;
  logic           sdaPrev_q;
  logic           latchOpen_q;
  logic           latch_q;
  logic           sclHold_q;
  logic [`USU_GAP_W-1:0] gapCnt_q;

  usu_edge_capture u_capture (
    .linkClk  (shiftClockPin),
    .arst_n   (arst_n),
    .dataIn   (serialDataInputPin),
    .posBit_q (posBit),
    .posTgl_q (posTgl),
    .negBit_q (negBit),
    .negTgl_q (negTgl)
  );

  usu_sync #(.W(4)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .async  ({posTgl, negTgl, serialDataInputPin, shiftClockPin}),
    .sync_q (syncd)
  );

  wire twoWire   = usuIsTwoWire(wireMode_q);
  wire diSync    = syncd[1];
  wire sclHigh   = syncd[0];
  wire posEvt    = syncd[3] ^ posTglD_q;
  wire negEvt    = syncd[2] ^ negTglD_q;
  // Captured bits are only read in the cycle their toggle lands, long after they settled
  wire sampleEvt = edgeSel_q ? negEvt : posEvt;
  wire outEvt    = edgeSel_q ? posEvt : negEvt;
  wire extBit    = edgeSel_q ? negBit : posBit;
  wire swStrobe  = ctrlWrite & ctrlClockStrobe & ~ctrlClockSource & ~ctrlClockEdge;
  wire toggleWr  = ctrlWrite & ctrlClockPinToggle;
  wire timerEvt  = ~srcExt_q & edgeSel_q & timerZeroOverflow;

  // Pin edge, timer overflow or software strobe drives both register and counter, except that toggle counting counts toggle writes
  wire shiftEvt = srcExt_q ? sampleEvt : (timerEvt | swStrobe);
  wire shiftBit = srcExt_q ? extBit : diSync;
  wire extEdge  = posEvt | negEvt;
  wire ctrEvt   = srcExt_q ? (countOnToggle_q ? toggleWr : extEdge) : shiftEvt;
  wire cntWrap  = ctrEvt & (counter_q == `USU_CNT_MAX);

  // Host write wins over a coinciding shift so the loaded byte is never corrupted
  wire [DataW-1:0] shiftData_d = dataWrite ? dataWdata :
                                 shiftEvt  ? {shiftData_q[DataW-2:0], shiftBit} :
                                 shiftData_q;
  wire [CntW-1:0]  counter_d   = statusWrite ? statusCounterValue :
                                 ctrEvt      ? counter_q + 1'b1 :
                                 counter_q;
  wire ovfClr      = statusWrite & statusClearOverflow;
  wire overflow_d  = cntWrap | (overflowFlag_q & ~ovfClr);

  wire sdaFall     = sdaPrev_q & ~diSync;
  wire startDet    = twoWire & sclHigh & sdaFall;
  wire startClr    = statusWrite & statusClearStart;
  wire start_d     = startDet | (startFlag_q & ~startClr);
  wire holdStart   = startFlag_q & (sclHold_q | ~sclHigh);
  wire holdOvf     = overflowFlag_q & (wireMode_q == USU_WM_TWO_HOLD);
  wire sclHold_d   = twoWire & (holdStart | holdOvf);

  // External clock: open after the output edge, shut at the sampling edge, where the register shifts
  wire latchOpen_d = ~srcExt_q | (outEvt ? 1'b1 : (sampleEvt ? 1'b0 : latchOpen_q));
  wire latch_d     = latchOpen_q ? shiftData_q[DataW-1] : latch_q;

  wire [`USU_GAP_W-1:0] minGap = twoWire ? `USU_GAP_W'(`USU_TWI_CLK_DIV / 2)
                                         : `USU_GAP_W'(`USU_SLAVE_CLK_DIV / 2);
  wire gapSat      = (gapCnt_q == {`USU_GAP_W{1'b1}});
  wire [`USU_GAP_W-1:0] gapCnt_d = extEdge ? `USU_GAP_W'(1) : (gapSat ? gapCnt_q : gapCnt_q + 1'b1);
  wire tooFast     = srcExt_q & ((extEdge & (gapCnt_q < minGap)) | (posEvt & negEvt));
  wire rateViol_d  = tooFast | (rateViolation_q & ~ctrlWrite);

  wire sckOut_d    = shiftClockPinOut_q ^ toggleWr;
  wire sclOeN_d    = ~(twoWire & (sclHold_q | ~shiftClockPinOut_q));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wireMode_q      <= USU_WM_OFF;
      srcExt_q        <= 1'b0;
      edgeSel_q       <= 1'b0;
      countOnToggle_q <= 1'b0;
    end else if (ctrlWrite) begin
      wireMode_q      <= ctrlWireMode;
      srcExt_q        <= ctrlClockSource;
      edgeSel_q       <= ctrlClockEdge;
      countOnToggle_q <= ctrlClockSource & ctrlClockStrobe;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      posTglD_q <= 1'b0;
      negTglD_q <= 1'b0;
      sdaPrev_q <= 1'b0;
      gapCnt_q  <= {`USU_GAP_W{1'b1}};
    end else begin
      posTglD_q <= syncd[3];
      negTglD_q <= syncd[2];
      sdaPrev_q <= diSync;
      gapCnt_q  <= gapCnt_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftData_q    <= `USU_DATA_RST;
      counter_q      <= `USU_CNT_RST;
      overflowFlag_q <= 1'b0;
      startFlag_q    <= 1'b0;
    end else begin
      shiftData_q    <= shiftData_d;
      counter_q      <= counter_d;
      overflowFlag_q <= overflow_d;
      startFlag_q    <= start_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latchOpen_q <= 1'b1;
      latch_q     <= 1'b0;
      sclHold_q   <= 1'b0;
    end else begin
      latchOpen_q <= latchOpen_d;
      latch_q     <= latch_d;
      sclHold_q   <= sclHold_d;
    end
  end

  // Open-drain lines only ever pull low; the enable alone decides the level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOutPin_q       <= 1'b0;
      sdaOut_q           <= 1'b0;
      sdaOe_n_q          <= 1'b1;
      shiftClockPinOut_q <= 1'b0;
      sclOut_q           <= 1'b0;
      sclOe_n_q          <= 1'b1;
    end else begin
      dataOutPin_q       <= ~twoWire & latch_q;
      sdaOut_q           <= 1'b0;
      sdaOe_n_q          <= ~twoWire | latch_q;
      shiftClockPinOut_q <= sckOut_d;
      sclOut_q           <= 1'b0;
      sclOe_n_q          <= sclOeN_d;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rateViolation_q <= 1'b0;
      wakeIdle_q      <= 1'b0;
      wakePowerDown_q <= 1'b0;
    end else begin
      rateViolation_q <= rateViol_d;
      wakeIdle_q      <= overflow_d;
      wakePowerDown_q <= twoWire & start_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_data_write;
    dataWrite |=> shiftData_q == $past(dataWdata);
  endproperty
  a_data_write: assert property (p_data_write) else $error("written byte not held");

  property p_left_shift;
    shiftEvt && !dataWrite |=> shiftData_q == {$past(shiftData_q[DataW-2:0]), $past(shiftBit)};
  endproperty
  a_left_shift: assert property (p_left_shift) else $error("shift did not move left");

  property p_wrap_sets_flag;
    ctrEvt && counter_q == `USU_CNT_MAX && !statusWrite |=> overflowFlag_q && counter_q == `USU_CNT_RST;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap did not set flag");

  property p_status_write;
    statusWrite && statusClearOverflow && !cntWrap |=> !overflowFlag_q && counter_q == $past(statusCounterValue);
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write not applied");

  property p_both_edges;
    srcExt_q && !countOnToggle_q && (negEvt ^ posEvt) && !statusWrite
      |=> counter_q == $past(counter_q) + 1'b1;
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("edge not counted");

  property p_latch_closed;
    srcExt_q && !latchOpen_q |=> latch_q == $past(latch_q);
  endproperty
  a_latch_closed: assert property (p_latch_closed) else $error("closed latch changed");

  property p_latch_internal;
    !srcExt_q && !ctrlWrite |=> latchOpen_q ##1 latch_q == $past(shiftData_q[DataW-1]);
  endproperty
  a_latch_internal: assert property (p_latch_internal) else $error("latch not transparent");

  property p_pin_route;
    !twoWire && !ctrlWrite |=> sdaOe_n_q && dataOutPin_q == $past(latch_q);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("wrong output pin used");

  property p_toggle_count;
    srcExt_q && countOnToggle_q && toggleWr && !statusWrite
      |=> shiftClockPinOut_q != $past(shiftClockPinOut_q) && counter_q == $past(counter_q) + 1'b1;
  endproperty
  a_toggle_count: assert property (p_toggle_count) else $error("toggle write not counted");

  property p_start_hold;
    startDet |=> startFlag_q ##[1:3] (sclHigh || !sclOe_n_q);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start not flagged or held");

  c_ext_byte:   cover property (srcExt_q && cntWrap);
  c_soft_byte:  cover property (swStrobe && counter_q == `USU_CNT_MAX);
  c_start:      cover property (startDet);
  c_write_clash: cover property (dataWrite && shiftEvt);
  c_ovf_hold:   cover property (holdOvf && twoWire);

  // Per-edge checks look at the captured bit itself, not at the muxed shiftBit
  property p_edge_mode0;
    srcExt_q && !edgeSel_q && posEvt && !dataWrite |=> shiftData_q == {$past(shiftData_q[DataW-2:0]), $past(posBit)};
  endproperty
  a_edge_mode0: assert property (p_edge_mode0) else $error("mode 0 did not sample on rise");

  property p_edge_mode1;
    srcExt_q && edgeSel_q && negEvt && !dataWrite |=> shiftData_q == {$past(shiftData_q[DataW-2:0]), $past(negBit)};
  endproperty
  a_edge_mode1: assert property (p_edge_mode1) else $error("mode 1 did not sample on fall");

  property p_out_edge_still;
    srcExt_q && !edgeSel_q && negEvt && !posEvt && !dataWrite |=> shiftData_q == $past(shiftData_q);
  endproperty
  a_out_edge_still: assert property (p_out_edge_still) else $error("shift on output edge");

  property p_wrap_set_wins;
    cntWrap |=> overflowFlag_q;
  endproperty
  a_wrap_set_wins: assert property (p_wrap_set_wins) else $error("wrap lost to clear");

  property p_ovf_hold;
    !cntWrap && !ovfClr |=> overflowFlag_q == $past(overflowFlag_q);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag moved by itself");

  property p_count_hold;
    !ctrEvt && !statusWrite |=> counter_q == $past(counter_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without event");

  property p_wake_idle;
    wakeIdle_q == overflowFlag_q;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("idle wake does not follow flag");

  property p_wake_two_wire;
    twoWire && startDet |=> wakePowerDown_q && startFlag_q;
  endproperty
  a_wake_two_wire: assert property (p_wake_two_wire) else $error("start did not wake");

  property p_ovf_scl_hold;
    wireMode_q == USU_WM_TWO_HOLD && overflowFlag_q && !ctrlWrite |=> ##1 !sclOe_n_q;
  endproperty
  a_ovf_scl_hold: assert property (p_ovf_scl_hold) else $error("clock not held after overflow");

  property p_rate_two_wire;
    srcExt_q && twoWire && extEdge && gapCnt_q < (`USU_TWI_CLK_DIV / 2) |=> rateViolation_q;
  endproperty
  a_rate_two_wire: assert property (p_rate_two_wire) else $error("fast two-wire clock missed");

  property p_rate_three_wire;
    srcExt_q && !twoWire && extEdge && gapCnt_q < (`USU_SLAVE_CLK_DIV / 2) |=> rateViolation_q;
  endproperty
  a_rate_three_wire: assert property (p_rate_three_wire) else $error("fast slave clock missed");

  property p_two_wire_pin;
    twoWire |=> !dataOutPin_q && sdaOe_n_q == $past(latch_q);
  endproperty
  a_two_wire_pin: assert property (p_two_wire_pin) else $error("two-wire pin routing wrong");

  property p_toggle_pin;
    toggleWr |=> shiftClockPinOut_q != $past(shiftClockPinOut_q);
  endproperty
  a_toggle_pin: assert property (p_toggle_pin) else $error("clock pin not toggled");

  // Strobe and timer act only when the stored source is internal
  property p_soft_strobe;
    !srcExt_q && swStrobe && !dataWrite && !statusWrite
      |=> counter_q == $past(counter_q) + 1'b1 && shiftData_q == {$past(shiftData_q[DataW-2:0]), $past(diSync)};
  endproperty
  a_soft_strobe: assert property (p_soft_strobe) else $error("strobe did not shift and count");

  property p_timer_count;
    !srcExt_q && edgeSel_q && timerZeroOverflow && !statusWrite |=> counter_q == $past(counter_q) + 1'b1;
  endproperty
  a_timer_count: assert property (p_timer_count) else $error("timer overflow not counted");

endmodule // usu_shift_unit

// ---- verilog/usu_sync.sv ----
`timescale 1ns/10ps
module usu_sync #(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] sync_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async;
      sync_q <= meta_q;
    end
  end

endmodule // usu_sync
